// [verilog/rxsc_pkg.sv]
package rxsc_pkg;
  localparam int unsigned AXI_ADDR_W = 14;
  localparam int unsigned NUM_CNT = 5;
  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_UCTRL_LO = 12'h930;
  localparam logic [11:0] IDX_UCTRL_HI = 12'h931;
  localparam logic [11:0] IDX_PAUSE_LO = 12'h932;
  localparam logic [11:0] IDX_PAUSE_HI = 12'h933;
  localparam logic [11:0] IDX_SHORT_LO = 12'h934;
  localparam logic [11:0] IDX_SHORT_HI = 12'h935;
  localparam logic [11:0] IDX_CONTROL = 12'h945;
  localparam logic [11:0] IDX_STATE = 12'h946;
  localparam logic [11:0] IDX_PAY_LO = 12'h960;
  localparam logic [11:0] IDX_PAY_HI = 12'h961;
  localparam logic [11:0] IDX_FRM_LO = 12'h962;
  localparam logic [11:0] IDX_FRM_HI = 12'h963;
  localparam logic [11:0] IDX_INT_STS = 12'h970;
  localparam logic [11:0] IDX_INT_MASK = 12'h971;
  localparam logic [11:0] IDX_RESERVED = 12'h940;
  localparam logic [3:0] STATS_PAGE = 4'h9;
  // Counter slots
  localparam int unsigned CNT_UCTRL = 0;
  localparam int unsigned CNT_PAUSE = 1;
  localparam int unsigned CNT_SHORT = 2;
  localparam int unsigned CNT_PAY = 3;
  localparam int unsigned CNT_FRM = 4;
  localparam logic [11:0] CNT_LO_IDX [NUM_CNT] = '{12'h930, 12'h932, 12'h934, 12'h960, 12'h962};
  // Control and state bit positions
  localparam int unsigned CTL_SHADOW = 2;
  localparam int unsigned CTL_PAR_CLR = 1;
  localparam int unsigned CTL_BULK_CLR = 0;
  localparam int unsigned STS_PAUSED = 1;
  localparam int unsigned STS_PAR_ERR = 0;
  // Interrupt bits
  localparam int unsigned INT_W = 3;
  localparam int unsigned INT_PAR_ERR = 0;
  localparam int unsigned INT_PAUSE = 1;
  localparam int unsigned INT_SHORT = 2;
  // Reset values
  localparam logic [63:0] CNT_RST = 64'h0;
  localparam logic [INT_W-1:0] INT_RST = 3'h0;
  // Frame length limits and tag sizes
  localparam logic [15:0] SHORT_MIN_LEN = 16'h0008;
  localparam logic [15:0] SHORT_LIM_LEN = 16'h0040;
  localparam logic [15:0] VLAN_ONE_BYTES = 16'h0004;
  localparam logic [15:0] VLAN_STACK_BYTES = 16'h0008;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic eof;
    logic ucast_ctrl;
    logic pause;
    logic fcs_err;
    logic undersize_err;
    logic oversize_err;
    logic len_err;
    logic [1:0] vlan_tags;
    logic [15:0] frame_len;
    logic [15:0] payload_len;
  } rxsc_frame_s;
endpackage

// [verilog/rxsc_top.sv]
`timescale 1ns/1ns
// Functional notes
// - Count a runt only when length is above eight and below 64 bytes.
// - Eight bytes or fewer is a decoding error, never counted as runt.
// - Pause counter increments on every pause frame, errored or not.
// - Counters are 64 bits; low word at even index, high word next.
// - Shadow bit set freezes read values; counting continues; writing 0 releases.
// - Writing 1 to parity clear clears parity status; bit reads back 0.
// - Writing 1 to bulk reset clears all counters together; bit self-clears.
// - Paused status bit follows the shadow request bit.
// - Parity status sets on any counter parity error, holds until cleared.
// - Payload octets add only frames without check, size or length errors.
// - With VLAN detection off, payload adds 4 or 8 tag bytes.
// - Frame octets add total length of frames without those errors.
module rxsc_top (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire rxsc_pkg::rxsc_frame_s frame_in,
  input wire logic vlan_detect_off_in,
  input wire logic s_axi_awvalid_in,
  input wire logic [rxsc_pkg::AXI_ADDR_W-1:0] s_axi_awaddr_in,
  output logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  output logic s_axi_wready_out,
  output logic s_axi_bvalid_out,
  output logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic [rxsc_pkg::AXI_ADDR_W-1:0] s_axi_araddr_in,
  output logic s_axi_arready_out,
  output logic s_axi_rvalid_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  input wire logic s_axi_rready_in,
  output logic irq_out
);
  import rxsc_pkg::*;

  logic [63:0] cnt_q [NUM_CNT];
  logic [63:0] shd_q [NUM_CNT];
  logic [63:0] cnt_d [NUM_CNT];
  logic [63:0] inc [NUM_CNT];
  logic [NUM_CNT-1:0] par_q;
  logic [NUM_CNT-1:0] par_mis;
  logic good;
  logic is_short;
  logic [15:0] vlan_add;
  logic [16:0] pay_sum;
  logic shadow_q;
  logic perr_q;
  logic [INT_W-1:0] int_sts_q;
  logic [INT_W-1:0] int_mask_q;
  logic [INT_W-1:0] int_ev;
  logic aw_hold_q;
  logic w_hold_q;
  logic [11:0] wr_idx_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_fire;
  logic wr_ctl;
  logic bulk_clr;
  logic par_clr;
  logic snap_take;
  logic ar_fire;
  logic [11:0] rd_idx;
  logic [11:0] wr_idx_in;
  logic [31:0] rd_val;

  // Frame classification
  always_comb begin
    good = ~(frame_in.fcs_err | frame_in.undersize_err | frame_in.oversize_err |
             frame_in.len_err);
    is_short = (frame_in.frame_len > SHORT_MIN_LEN) && (frame_in.frame_len < SHORT_LIM_LEN);
    vlan_add = 16'h0000;
    if (vlan_detect_off_in) begin
      if (frame_in.vlan_tags == 2'h2) begin
        vlan_add = VLAN_STACK_BYTES;
      end else if (frame_in.vlan_tags == 2'h1) begin
        vlan_add = VLAN_ONE_BYTES;
      end
    end
    pay_sum = {1'b0, frame_in.payload_len} + {1'b0, vlan_add};
    for (int i = 0; i < NUM_CNT; i++) begin
      inc[i] = 64'h0;
    end
    if (frame_in.eof) begin
      if (frame_in.ucast_ctrl && good) begin
        inc[CNT_UCTRL] = 64'h1;
      end
      if (frame_in.pause) begin
        inc[CNT_PAUSE] = 64'h1;
      end
      if (is_short) begin
        inc[CNT_SHORT] = 64'h1;
      end
      if (good) begin
        inc[CNT_PAY] = {47'h0, pay_sum};
        inc[CNT_FRM] = {48'h0, frame_in.frame_len};
      end
    end
    for (int i = 0; i < NUM_CNT; i++) begin
      cnt_d[i] = cnt_q[i] + inc[i];
      par_mis[i] = par_q[i] ^ (^cnt_q[i]);
    end
  end

  // Write channel
  assign wr_idx_in = s_axi_awaddr_in[13:2];
  assign s_axi_awready_out = ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready_out = ~w_hold_q & ~bvalid_q;
  assign wr_fire = aw_hold_q & w_hold_q & ~bvalid_q;
  assign wr_ctl = wr_fire & wstrb_q[0] & (wr_idx_q == IDX_CONTROL);
  assign bulk_clr = wr_ctl & wdata_q[CTL_BULK_CLR];
  assign par_clr = wr_ctl & wdata_q[CTL_PAR_CLR];
  assign snap_take = wr_ctl & wdata_q[CTL_SHADOW] & ~shadow_q;

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      aw_hold_q <= 1'b0;
      wr_idx_q <= 12'h000;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_hold_q <= 1'b1;
      wr_idx_q <= wr_idx_in;
    end else if (wr_fire) begin
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      w_hold_q <= 1'b0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_hold_q <= 1'b1;
      wdata_q <= s_axi_wdata_in;
      wstrb_q <= s_axi_wstrb_in;
    end else if (wr_fire) begin
      w_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= (wr_idx_q[11:8] == STATS_PAGE) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;

  // Control register
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      shadow_q <= 1'b0;
    end else if (wr_ctl) begin
      shadow_q <= wdata_q[CTL_SHADOW];
    end
  end

  // Counters and parity
  always_ff @(posedge ref_clk_in) begin
    for (int i = 0; i < NUM_CNT; i++) begin
      if (reset_in || bulk_clr) begin
        cnt_q[i] <= CNT_RST;
        par_q[i] <= 1'b0;
      end else begin
        cnt_q[i] <= cnt_d[i];
        par_q[i] <= ^cnt_d[i];
      end
    end
  end

  // Snapshot copies
  always_ff @(posedge ref_clk_in) begin
    for (int i = 0; i < NUM_CNT; i++) begin
      if (reset_in) begin
        shd_q[i] <= CNT_RST;
      end else if (snap_take) begin
        shd_q[i] <= cnt_q[i];
      end
    end
  end

  // Parity error status, set wins over clear
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      perr_q <= 1'b0;
    end else if (|par_mis) begin
      perr_q <= 1'b1;
    end else if (par_clr) begin
      perr_q <= 1'b0;
    end
  end

  // Interrupt status and mask
  always_comb begin
    int_ev = INT_RST;
    int_ev[INT_PAR_ERR] = |par_mis;
    int_ev[INT_PAUSE] = inc[CNT_PAUSE][0];
    int_ev[INT_SHORT] = inc[CNT_SHORT][0];
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      int_sts_q <= INT_RST;
    end else if (wr_fire && wstrb_q[0] && wr_idx_q == IDX_INT_STS) begin
      int_sts_q <= (int_sts_q & ~wdata_q[INT_W-1:0]) | int_ev;
    end else begin
      int_sts_q <= int_sts_q | int_ev;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      int_mask_q <= INT_RST;
    end else if (wr_fire && wstrb_q[0] && wr_idx_q == IDX_INT_MASK) begin
      int_mask_q <= wdata_q[INT_W-1:0];
    end
  end

  assign irq_out = |(int_sts_q & int_mask_q);

  // Read channel
  assign rd_idx = s_axi_araddr_in[13:2];
  assign s_axi_arready_out = ~rvalid_q;
  assign ar_fire = s_axi_arvalid_in & ~rvalid_q;

  always_comb begin
    rd_val = 32'h0;
    for (int i = 0; i < NUM_CNT; i++) begin
      if (rd_idx == CNT_LO_IDX[i]) begin
        rd_val = shadow_q ? shd_q[i][31:0] : cnt_q[i][31:0];
      end else if (rd_idx == CNT_LO_IDX[i] + 12'h001) begin
        rd_val = shadow_q ? shd_q[i][63:32] : cnt_q[i][63:32];
      end
    end
    if (rd_idx == IDX_CONTROL) begin
      rd_val[CTL_SHADOW] = shadow_q;
    end else if (rd_idx == IDX_STATE) begin
      rd_val[STS_PAUSED] = shadow_q;
      rd_val[STS_PAR_ERR] = perr_q;
    end else if (rd_idx == IDX_INT_STS) begin
      rd_val[INT_W-1:0] = int_sts_q;
    end else if (rd_idx == IDX_INT_MASK) begin
      rd_val[INT_W-1:0] = int_mask_q;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= (rd_idx[11:8] == STATS_PAGE) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready_in) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;

  // Checks
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);

  property p_short_count;
    frame_in.eof && frame_in.frame_len > 16'h0008 && frame_in.frame_len < 16'h0040 &&
      !bulk_clr |=> cnt_q[CNT_SHORT] == $past(cnt_q[CNT_SHORT]) + 64'h1;
  endproperty
  a_short_count: assert property (p_short_count)
    else $error("runt frame not counted");

  property p_tiny_not_short;
    frame_in.eof && frame_in.frame_len <= 16'h0008 && !bulk_clr |=>
      cnt_q[CNT_SHORT] == $past(cnt_q[CNT_SHORT]);
  endproperty
  a_tiny_not_short: assert property (p_tiny_not_short)
    else $error("decoding error counted as runt");

  property p_pause_err;
    frame_in.eof && frame_in.pause && frame_in.fcs_err && !bulk_clr |=>
      cnt_q[CNT_PAUSE] == $past(cnt_q[CNT_PAUSE]) + 64'h1;
  endproperty
  a_pause_err: assert property (p_pause_err)
    else $error("errored pause frame not counted");

  property p_high_word;
    ar_fire && rd_idx == IDX_PAUSE_HI && !shadow_q |=>
      s_axi_rvalid_out && s_axi_rdata_out == $past(cnt_q[CNT_PAUSE][63:32]);
  endproperty
  a_high_word: assert property (p_high_word)
    else $error("high word read wrong");

  sequence s_snap_set;
    wr_ctl && wdata_q[CTL_SHADOW] && !shadow_q;
  endsequence
  sequence s_frozen_read;
    shadow_q && ar_fire && rd_idx == IDX_FRM_LO;
  endsequence
  property p_snap_take;
    s_snap_set |=> shadow_q && shd_q[CNT_FRM] == $past(cnt_q[CNT_FRM]);
  endproperty
  a_snap_take: assert property (p_snap_take)
    else $error("snapshot not captured");
  property p_frozen_read;
    s_frozen_read |=> s_axi_rdata_out == $past(shd_q[CNT_FRM][31:0]);
  endproperty
  a_frozen_read: assert property (p_frozen_read)
    else $error("read not from snapshot");

  property p_par_clear;
    par_clr && par_mis == '0 |=> !perr_q ##1 !perr_q || $past(|par_mis);
  endproperty
  a_par_clear: assert property (p_par_clear)
    else $error("parity status not cleared");

  property p_bulk;
    bulk_clr |=> cnt_q[CNT_PAY] == 64'h0 && cnt_q[CNT_FRM] == 64'h0 &&
      cnt_q[CNT_UCTRL] == 64'h0;
  endproperty
  a_bulk: assert property (p_bulk)
    else $error("bulk reset missed a counter");

  property p_paused_read;
    ar_fire && rd_idx == IDX_STATE |=> s_axi_rdata_out[STS_PAUSED] == $past(shadow_q);
  endproperty
  a_paused_read: assert property (p_paused_read)
    else $error("paused status mismatch");

  property p_perr_hold;
    perr_q && !par_clr |=> perr_q;
  endproperty
  a_perr_hold: assert property (p_perr_hold)
    else $error("parity status dropped");

  property p_pay_good;
    frame_in.eof && good && !vlan_detect_off_in && !bulk_clr |=>
      cnt_q[CNT_PAY] == $past(cnt_q[CNT_PAY]) + {48'h0, $past(frame_in.payload_len)};
  endproperty
  a_pay_good: assert property (p_pay_good)
    else $error("payload octets wrong");

  property p_pay_stack;
    frame_in.eof && good && vlan_detect_off_in && frame_in.vlan_tags == 2'h2 &&
      !bulk_clr |=> cnt_q[CNT_PAY] ==
      $past(cnt_q[CNT_PAY]) + {48'h0, $past(frame_in.payload_len)} + 64'h8;
  endproperty
  a_pay_stack: assert property (p_pay_stack)
    else $error("stacked tag bytes not added");

  property p_frm_bad;
    frame_in.eof && frame_in.fcs_err && !bulk_clr |=>
      cnt_q[CNT_FRM] == $past(cnt_q[CNT_FRM]) && cnt_q[CNT_PAY] == $past(cnt_q[CNT_PAY]);
  endproperty
  a_frm_bad: assert property (p_frm_bad)
    else $error("errored frame octets counted");

  property p_idle_hold;
    !frame_in.eof && !bulk_clr |=> cnt_q[CNT_FRM] == $past(cnt_q[CNT_FRM]);
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("counter moved without end of frame");

  property p_reserved;
    ar_fire && rd_idx == IDX_RESERVED |=> s_axi_rdata_out == 32'h0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved address not zero");
endmodule

// [testbench/rxsc_frame_src.sv]
`timescale 1ns/1ns
module rxsc_frame_src (
  input wire logic ref_clk_in,
  output rxsc_pkg::rxsc_frame_s frame_out
);
  import rxsc_pkg::*;
  rxsc_frame_s q[$];
  initial begin
    frame_out = '0;
  end
  // One queued result per cycle; with the queue empty, eof is low and the other fields invert each cycle
  always @(posedge ref_clk_in) begin
    if (q.size() != 0) begin
      frame_out <= q.pop_front();
    end else begin
      frame_out <= {1'b0, ~frame_out[39:0]};
    end
  end
endmodule

// [testbench/rx_statistics_counters_test.sv]
`timescale 1ns/1ns
module rx_statistics_counters_test;
  import rxsc_pkg::*;
  localparam logic [15:0] LENS [4] = '{16'h0008, 16'h0009, 16'h003F, 16'h0040};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic voff = 1'b0;
  rxsc_frame_s frm;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic brdy = 1'b0;
  logic arv = 1'b0;
  logic rrdy = 1'b0;
  logic awr, wr, bv, arr, rv, irq;
  logic [AXI_ADDR_W-1:0] awa = '0;
  logic [AXI_ADDR_W-1:0] ara = '0;
  logic [31:0] wd = '0;
  logic [3:0] ws = 4'hF;
  logic [31:0] rd;
  logic [31:0] v;
  logic [1:0] br, rr, rsp;
  int num_errors = 0;
  int n_checks = 0;
  longint unsigned c [NUM_CNT] = '{default: 0};
  longint unsigned snap [NUM_CNT];
  logic [2:0] ist = 3'h0;
  logic shadow = 1'b0;
  logic [31:0] seed = 32'h1F;

  always #5 clk = ~clk;

  rxsc_frame_src src (.ref_clk_in(clk), .frame_out(frm));

  rxsc_top dut (.ref_clk_in(clk), .reset_in(rst), .frame_in(frm), .vlan_detect_off_in(voff),
    .s_axi_awvalid_in(awv), .s_axi_awaddr_in(awa), .s_axi_awready_out(awr),
    .s_axi_wvalid_in(wv), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wready_out(wr),
    .s_axi_bvalid_out(bv), .s_axi_bresp_out(br), .s_axi_bready_in(brdy),
    .s_axi_arvalid_in(arv), .s_axi_araddr_in(ara), .s_axi_arready_out(arr),
    .s_axi_rvalid_out(rv), .s_axi_rdata_out(rd), .s_axi_rresp_out(rr),
    .s_axi_rready_in(rrdy), .irq_out(irq));

  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic axi_wr(input logic [11:0] idx, input logic [31:0] d, output logic [1:0] r);
    bit ta, tw, tb;
    int n;
    tb = 0;
    n = 0;
    r = 2'h3;
    @(posedge clk);
    awv <= 1'b1;
    awa <= {idx, 2'h0};
    wv <= 1'b1;
    wd <= d;
    brdy <= 1'b1;
    while (!tb && n < 100) begin
      @(negedge clk);
      ta = awv & awr;
      tw = wv & wr;
      tb = bv & brdy;
      if (tb) r = br;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tb) brdy <= 1'b0;
      n++;
    end
    if (!tb) num_errors++;
  endtask

  task automatic axi_rd(input logic [11:0] idx, output logic [31:0] d, output logic [1:0] r);
    bit ta, tr;
    int n;
    tr = 0;
    n = 0;
    @(posedge clk);
    arv <= 1'b1;
    ara <= {idx, 2'h0};
    rrdy <= 1'b1;
    while (!tr && n < 100) begin
      @(negedge clk);
      ta = arv & arr;
      tr = rv & rrdy;
      if (tr) d = rd;
      if (tr) r = rr;
      @(posedge clk);
      if (ta) arv <= 1'b0;
      if (tr) rrdy <= 1'b0;
      n++;
    end
    if (!tr) num_errors++;
  endtask

  task automatic rck(input string nm, input logic [11:0] idx, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(idx, d, r);
    check(nm, {32'h0, d}, {32'h0, e});
    check({nm, " resp"}, {62'h0, r}, {62'h0, RESP_OKAY});
  endtask

  task automatic cnt_all();
    longint unsigned e;
    for (int i = 0; i < NUM_CNT; i++) begin
      e = shadow ? snap[i] : c[i];
      rck($sformatf("cnt%0d lo", i), CNT_LO_IDX[i], e[31:0]);
      rck($sformatf("cnt%0d hi", i), CNT_LO_IDX[i] + 12'h1, e[63:32]);
    end
  endtask

  function automatic void model(input rxsc_frame_s f);
    logic good;
    longint unsigned tag;
    good = !(f.fcs_err | f.undersize_err | f.oversize_err | f.len_err);
    tag = !voff ? 0 : (f.vlan_tags == 2'h1 ? 4 : (f.vlan_tags == 2'h2 ? 8 : 0));
    if (good && f.ucast_ctrl) c[CNT_UCTRL]++;
    if (f.pause) c[CNT_PAUSE]++;
    if (f.pause) ist[INT_PAUSE] = 1'b1;
    if (f.frame_len > 16'h0008 && f.frame_len < 16'h0040) begin
      c[CNT_SHORT]++;
      ist[INT_SHORT] = 1'b1;
    end
    if (good) c[CNT_PAY] += f.payload_len + tag;
    if (good) c[CNT_FRM] += f.frame_len;
  endfunction

  // Queue random results back to back, first four at length boundaries
  task automatic send(input int num);
    rxsc_frame_s f;
    int n;
    @(negedge clk);
    for (int i = 0; i < num; i++) begin
      seed = lfsr(seed);
      f = {1'b1, seed[1:0], &seed[3:2], &seed[6:4], &seed[9:7], &seed[12:10],
        (seed[14:13] == 2'h3 ? 2'h2 : seed[14:13]), 9'h0, seed[22:16], 10'h0, seed[28:23]};
      if (i < 4) f.frame_len = LENS[i];
      model(f);
      src.q.push_back(f);
    end
    n = 0;
    while (src.q.size() != 0 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    wrap_up();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    cnt_all();
    rck("control", IDX_CONTROL, 32'h0);
    rck("state", IDX_STATE, 32'h0);
    axi_wr(IDX_RESERVED, 32'hFFFFFFFF, rsp);
    check("reserved wr resp", {62'h0, rsp}, {62'h0, RESP_OKAY});
    rck("reserved", IDX_RESERVED, 32'h0);
    axi_rd(12'h100, v, rsp);
    check("outside resp", {62'h0, rsp}, {62'h0, RESP_SLVERR});
    check("outside data", {32'h0, v}, 64'h0);
    axi_wr(12'h545, 32'h4, rsp);
    check("outside wr resp", {62'h0, rsp}, {62'h0, RESP_SLVERR});
    @(posedge clk);
    ws <= 4'h0;
    axi_wr(IDX_CONTROL, 32'h4, rsp);
    @(posedge clk);
    ws <= 4'hF;
    rck("control no strobe", IDX_CONTROL, 32'h0);
    $display("test reset done");
    send(24);
    cnt_all();
    @(posedge clk);
    voff <= 1'b1;
    send(24);
    cnt_all();
    $display("test frames done");
    rck("int status", IDX_INT_STS, {29'h0, ist});
    @(negedge clk);
    check("irq masked", {63'h0, irq}, 64'h0);
    axi_wr(IDX_INT_MASK, 32'h6, rsp);
    @(negedge clk);
    check("irq raised", {63'h0, irq}, {63'h0, |ist[2:1]});
    axi_wr(IDX_INT_STS, 32'h6, rsp);
    ist = 3'h0;
    @(negedge clk);
    check("irq cleared", {63'h0, irq}, 64'h0);
    rck("int cleared", IDX_INT_STS, 32'h0);
    $display("test interrupt done");
    axi_wr(IDX_CONTROL, 32'h4, rsp);
    shadow = 1'b1;
    snap = c;
    rck("state paused", IDX_STATE, 32'h2);
    rck("control shadow", IDX_CONTROL, 32'h4);
    send(10);
    cnt_all();
    axi_wr(IDX_CONTROL, 32'h0, rsp);
    shadow = 1'b0;
    cnt_all();
    rck("state live", IDX_STATE, 32'h0);
    $display("test snapshot done");
    axi_wr(IDX_CONTROL, 32'h2, rsp);
    rck("parity clear", IDX_CONTROL, 32'h0);
    rck("parity state", IDX_STATE, 32'h0);
    axi_wr(IDX_CONTROL, 32'h1, rsp);
    c = '{default: 0};
    rck("bulk self clear", IDX_CONTROL, 32'h0);
    cnt_all();
    send(6);
    cnt_all();
    $display("test bulk reset done");
    wrap_up();
  end
endmodule
